//--- shared/reg_access_if.sv
// Internal register access strobe between the bus slave and register file.
// Assumes one access pulse per bus cycle, qualified by the slave.
`timescale 1ns/10ps

interface reg_access_if;
  import temp_mon_pkg::*;
  logic wr;
  logic [IDX_W-1:0] idx;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;

  modport slave (output wr, output idx, output wdata, input rdata);
  modport regs (input wr, input idx, input wdata, output rdata);
endinterface

//--- shared/temp_mon_pkg.sv
// Constants for the two-channel remote-diode temperature monitor.
// Assumes an 8-bit register window reached through a 32-bit Wishbone slave.
//
// Overview of operation
// [R1] Routing bits 3 and 1 pass channel 2/1 overtemp events to IRQ, reset 0.
// [R2] Routing bits 2 and 0 pass channel 2/1 warning events; bits 7-4 reserved.
// [R3] Global config bit 1 picks external reference when 1; resets to 1.
// [R4] Internal reference is used if either monitor asks for internal.
// [R5] Global config bit 0 selects standby when 1; resets to 1.
// [R6] Bank selector code 0 shows channel 1, code 1 shows channel 2.
// [R7] Channel config/status is forced to 00h on analog supply power-up.
// [R8] Limit flags 3-1 clear only by writing 1; writing 0 keeps them.
// [R9] Bit 7 sets on each new result load; cleared by writing 1.
// [R10] Bit 6 flags an open diode fault; cleared by writing 1.
// [R11] Bit 5 enables overtemp shutdown output, bit 4 warning output; reset 0.
// [R12] Bit 3 sets when temperature exceeds overtemp limit; write 1 clears.
// [R13] Bit 2 sets when temperature exceeds high limit; write 1 clears.
// [R14] Bit 1 sets when a loaded value is below low limit; write 1 clears.
// [R15] Bit 0 is the read/write channel enable, reset 0.
// [R16] Result register holds latest 8-bit two's complement reading, reset 0.
// [R17] Every channel register is kept per channel, shown by bank selector.
// [R18] Standby stops conversions; registers stay readable and writable.
// [R19] High limit resets to 7Fh and is compared with each new reading.
// [R20] IRQ is high while any event flag meets its routing enable.
// [R21] Reserved bits and reserved bank codes have no effect, read as 0.

package temp_mon_pkg;
  localparam int NUM_CH = 2;
  localparam int DATA_W = 8;
  localparam int IDX_W = 4;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_ROUTING = 4'h4;
  localparam logic [IDX_W-1:0] IDX_GCFG = 4'h8;
  localparam logic [IDX_W-1:0] IDX_BANK = 4'h9;
  localparam logic [IDX_W-1:0] IDX_CFGST = 4'ha;
  localparam logic [IDX_W-1:0] IDX_RESULT = 4'hb;
  localparam logic [IDX_W-1:0] IDX_HI_LIM = 4'hc;
  localparam logic [IDX_W-1:0] IDX_LO_LIM = 4'hd;
  localparam logic [IDX_W-1:0] IDX_OT_LIM = 4'he;

  // Global config fields
  localparam int GCFG_STANDBY = 0;
  localparam int GCFG_EXT_REF = 1;
  localparam logic [1:0] GCFG_RST = 2'h3;

  // Channel config/status fields
  localparam int CS_EN = 0;
  localparam int CS_LO = 1;
  localparam int CS_HI = 2;
  localparam int CS_OT = 3;
  localparam int CS_WARN_EN = 4;
  localparam int CS_OTS_EN = 5;
  localparam int CS_OPEN = 6;
  localparam int CS_EOC = 7;
  localparam logic [7:0] CS_W1C_MASK = 8'hce;
  localparam logic [7:0] CS_RW_MASK = 8'h31;
  localparam logic [7:0] CS_RST = 8'h00;

  localparam logic [3:0] ROUTING_RST = 4'h0;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] HI_LIM_RST = 8'h7f;
  localparam logic [7:0] LO_LIM_RST = 8'hc9;
  localparam logic [7:0] OT_LIM_RST = 8'h7f;
endpackage

//--- src/event_irq_router.sv
// Gates channel events with routing enables onto one interrupt request.
// Assumes events are the level flags held in the channel registers.
`timescale 1ns/10ps

module event_irq_router (
  input wire logic i_clk, // Clock
  input wire logic i_srst, // Sync reset
  input wire logic [3:0] i_event, // Overtemp/warning per channel
  input wire logic [3:0] i_enable, // Routing enables
  output logic o_irq // Interrupt request
);
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(i_event & i_enable); // R20
    end
  end
endmodule

//--- src/temp_channel_ctrl.sv
// Top of the temperature monitor register and channel control logic.
// Assumes the analog converter hands over one result per pulse on i_conv_*.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps

module temp_channel_ctrl
  import temp_mon_pkg::*;
(
  input wire logic i_clk, // Clock, 25 MHz
  input wire logic i_srst, // Sync reset, active high
  input wire logic i_wb_cyc, // Wishbone cycle
  input wire logic i_wb_stb, // Wishbone strobe
  input wire logic i_wb_we, // Wishbone write
  input wire logic [7:0] i_wb_adr, // Wishbone byte address
  input wire logic [3:0] i_wb_sel, // Wishbone byte selects
  input wire logic [31:0] i_wb_dat, // Wishbone write data
  output logic [31:0] o_wb_dat, // Wishbone read data
  output logic o_wb_ack, // Wishbone acknowledge
  input wire logic i_analog_supply_up, // Analog supply power-up pulse
  input wire logic i_vlm_int_ref, // Voltage monitor wants internal ref
  input wire logic i_conv_valid, // New conversion result
  input wire logic i_conv_chan, // Channel of result, 0 or 1
  input wire logic [7:0] i_conv_temp, // Result, two's complement
  input wire logic i_conv_open, // Open diode seen on this result
  output logic [1:0] o_conv_run, // Channel may start conversions
  output logic o_standby, // Standby in force
  output logic o_ext_ref, // External reference in use
  output logic [1:0] o_warning, // Warning output per channel
  output logic [1:0] o_overtemp_shutdown, // Shutdown output per channel
  output logic o_irq // Interrupt request
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------

  reg_access_if acc ();

  wb_reg_slave u_slave (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_cyc(i_wb_cyc),
    .i_stb(i_wb_stb),
    .i_we(i_wb_we),
    .i_adr(i_wb_adr),
    .i_sel(i_wb_sel),
    .i_dat(i_wb_dat),
    .o_dat(o_wb_dat),
    .o_ack(o_wb_ack),
    .acc(acc)
  );

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Write strobe for one register index
  function automatic logic reg_wr(
    input logic wr,
    input logic [IDX_W-1:0] idx,
    input logic [IDX_W-1:0] target
  );
    reg_wr = wr & (idx == target);
  endfunction

  // Signed compare of two readings; true when the first is above the second
  function automatic logic temp_above(
    input logic [DATA_W-1:0] temp,
    input logic [DATA_W-1:0] limit
  );
    temp_above = $signed(temp) > $signed(limit);
  endfunction

  // Channel registers take writes only through the bank in view
  function automatic logic chan_wr(
    input logic wr,
    input logic in_view,
    input logic [IDX_W-1:0] idx,
    input logic [IDX_W-1:0] target
  );
    chan_wr = in_view & reg_wr(wr, idx, target);
  endfunction

  // ----------------------------------------------------------------
  // Global registers
  // ----------------------------------------------------------------

  logic [3:0] routing;
  logic [1:0] gcfg;
  logic bank;
  logic [3:0] next_routing;
  logic [1:0] next_gcfg;
  logic next_bank;
  logic bank_code_ok;

  // Bits 7-4 are reserved, so only codes 0 and 1 in bits 3-0 move the view
  assign bank_code_ok = (acc.wdata[3:1] == 3'h0); // R6 R21

  // Reserved bits are not stored, so they read back as zero
  always_comb begin
    next_routing = routing;
    next_gcfg = gcfg;
    next_bank = bank;
    if (reg_wr(acc.wr, acc.idx, IDX_ROUTING)) begin
      next_routing = acc.wdata[3:0]; // R1 R2 R21
    end
    if (reg_wr(acc.wr, acc.idx, IDX_GCFG)) begin
      next_gcfg = acc.wdata[1:0]; // R3 R5 R21
    end
    if (reg_wr(acc.wr, acc.idx, IDX_BANK) && bank_code_ok) begin
      next_bank = acc.wdata[0]; // R6 R21
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      routing <= ROUTING_RST;
    end else begin
      routing <= next_routing;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      gcfg <= GCFG_RST; // R3 R5
    end else begin
      gcfg <= next_gcfg;
    end
  end

  // Reserved bank codes are dropped so the view never points nowhere
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bank <= 1'b0;
    end else begin
      bank <= next_bank;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel registers
  // ----------------------------------------------------------------

  logic [7:0] cfgst [NUM_CH];
  logic [7:0] result [NUM_CH];
  logic [7:0] hi_lim [NUM_CH];
  logic [7:0] lo_lim [NUM_CH];
  logic [7:0] ot_lim [NUM_CH];
  logic [NUM_CH-1:0] ch_warn;
  logic [NUM_CH-1:0] ch_ot;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic sel_ch;
      logic load;
      logic wr_cs;
      logic [7:0] clr;
      logic [7:0] set;
      logic [7:0] flags;
      logic [7:0] ctrl;
      logic [7:0] next_flags;
      logic [7:0] next_ctrl;
      logic wr_hi;
      logic wr_lo;
      logic wr_ot;
      logic above_hi;
      logic above_ot;
      logic below_lo;

      // Only the bank that is in view takes writes
      assign sel_ch = (bank == 1'(ch)); // R17 R6
      assign wr_cs = chan_wr(acc.wr, sel_ch, acc.idx, IDX_CFGST);
      assign wr_hi = chan_wr(acc.wr, sel_ch, acc.idx, IDX_HI_LIM);
      assign wr_lo = chan_wr(acc.wr, sel_ch, acc.idx, IDX_LO_LIM);
      assign wr_ot = chan_wr(acc.wr, sel_ch, acc.idx, IDX_OT_LIM);

      // Results land even in standby; standby only blocks new starts
      assign load = i_conv_valid & (i_conv_chan == 1'(ch)) & ctrl[CS_EN];

      // Strict compares: a reading equal to a limit raises no flag
      assign above_hi = temp_above(i_conv_temp, hi_lim[ch]); // R19
      assign above_ot = temp_above(i_conv_temp, ot_lim[ch]);
      assign below_lo = temp_above(lo_lim[ch], i_conv_temp);

      always_comb begin
        set = 8'h00;
        set[CS_EOC] = load; // R9
        set[CS_OPEN] = load & i_conv_open; // R10
        set[CS_OT] = load & above_ot; // R12
        set[CS_HI] = load & above_hi; // R13
        set[CS_LO] = load & below_lo; // R14
      end

      // Writing 0 to a sticky bit leaves it alone
      assign clr = wr_cs ? (acc.wdata & CS_W1C_MASK) : 8'h00; // R8

      // A set in the clearing cycle wins, so no event is lost to a late clear
      assign next_flags = ((flags & ~clr) | set) & CS_W1C_MASK; // R8
      // Enable bits are plain read/write; no event ever reaches them
      assign next_ctrl = wr_cs ? (acc.wdata & CS_RW_MASK) : ctrl; // R11 R15

      // Sticky flags
      always_ff @(posedge i_clk) begin
        if (i_srst || i_analog_supply_up) begin
          flags <= CS_RST & CS_W1C_MASK; // R7
        end else begin
          flags <= next_flags;
        end
      end

      // Output and channel enables
      always_ff @(posedge i_clk) begin
        if (i_srst || i_analog_supply_up) begin
          ctrl <= CS_RST & CS_RW_MASK; // R7 R11 R15
        end else begin
          ctrl <= next_ctrl;
        end
      end

      assign cfgst[ch] = flags | ctrl;

      // --------------------------------------------------------------
      // Channel result and limits
      // --------------------------------------------------------------

      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          result[ch] <= RESULT_RST; // R16
        end else if (load) begin
          result[ch] <= i_conv_temp; // R16
        end
      end

      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          hi_lim[ch] <= HI_LIM_RST; // R19
        end else if (wr_hi) begin
          hi_lim[ch] <= acc.wdata;
        end
      end

      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          lo_lim[ch] <= LO_LIM_RST;
        end else if (wr_lo) begin
          lo_lim[ch] <= acc.wdata;
        end
      end

      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          ot_lim[ch] <= OT_LIM_RST;
        end else if (wr_ot) begin
          ot_lim[ch] <= acc.wdata;
        end
      end

      // Open diode counts toward both alarm classes
      assign ch_warn[ch] = cfgst[ch][CS_HI] | cfgst[ch][CS_LO] | cfgst[ch][CS_OPEN];
      assign ch_ot[ch] = cfgst[ch][CS_OT] | cfgst[ch][CS_OPEN];

      // --------------------------------------------------------------
      // Channel outputs
      // --------------------------------------------------------------

      // Conversions start only out of standby and on an enabled channel
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          o_conv_run[ch] <= 1'b0;
        end else begin
          o_conv_run[ch] <= ~gcfg[GCFG_STANDBY] & ctrl[CS_EN]; // R18 R5
        end
      end

      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          o_warning[ch] <= 1'b0;
        end else begin
          o_warning[ch] <= ctrl[CS_WARN_EN] & ch_warn[ch]; // R11
        end
      end

      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          o_overtemp_shutdown[ch] <= 1'b0;
        end else begin
          o_overtemp_shutdown[ch] <= ctrl[CS_OTS_EN] & ch_ot[ch]; // R11
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------

  // Reads are side-effect free, so standby never blocks them
  always_comb begin
    acc.rdata = 8'h00;
    unique case (acc.idx)
      IDX_ROUTING: acc.rdata = {4'h0, routing}; // R21
      IDX_GCFG: acc.rdata = {6'h00, gcfg}; // R21
      IDX_BANK: acc.rdata = {7'h00, bank}; // R21
      IDX_CFGST: acc.rdata = cfgst[bank]; // R17 R18
      IDX_RESULT: acc.rdata = result[bank]; // R16 R17
      IDX_HI_LIM: acc.rdata = hi_lim[bank];
      IDX_LO_LIM: acc.rdata = lo_lim[bank];
      IDX_OT_LIM: acc.rdata = ot_lim[bank];
      default: acc.rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Global outputs
  // ----------------------------------------------------------------

  // Internal reference wins if either monitor asks for it
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_ext_ref <= GCFG_RST[GCFG_EXT_REF];
    end else begin
      o_ext_ref <= gcfg[GCFG_EXT_REF] & ~i_vlm_int_ref; // R3 R4
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_standby <= GCFG_RST[GCFG_STANDBY];
    end else begin
      o_standby <= gcfg[GCFG_STANDBY]; // R5 R18
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------

  event_irq_router u_irq (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_event({ch_ot[1], ch_warn[1], ch_ot[0], ch_warn[0]}), // R1 R2
    .i_enable(routing),
    .o_irq(o_irq)
  );

endmodule

//--- src/wb_reg_slave.sv
// Classic Wishbone slave: one access per request, ack one cycle later.
// Assumes the master holds the request until it sees ack.
`timescale 1ns/10ps

module wb_reg_slave
  import temp_mon_pkg::*;
(
  input wire logic i_clk, // Clock
  input wire logic i_srst, // Sync reset
  input wire logic i_cyc, // Bus cycle
  input wire logic i_stb, // Strobe
  input wire logic i_we, // Write enable
  input wire logic [7:0] i_adr, // Byte address
  input wire logic [3:0] i_sel, // Byte selects
  input wire logic [31:0] i_dat, // Write data
  output logic [31:0] o_dat, // Read data
  output logic o_ack, // Acknowledge
  reg_access_if.slave acc // Register strobe
);
  logic take;
  logic mapped;

  // Ack drops the cycle after it was given, so one request is one access
  assign take = i_cyc & i_stb & ~o_ack;
  assign mapped = (i_adr[1:0] == 2'h0) & ~|i_adr[7:6];
  assign acc.idx = i_adr[5:2];
  assign acc.wdata = i_dat[7:0];
  assign acc.wr = take & i_we & i_sel[0] & mapped;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_ack <= 1'b0;
    end else begin
      o_ack <= take;
    end
  end

  // Unmapped addresses still ack and read as zero
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_dat <= 32'h0;
    end else if (take) begin
      o_dat <= (mapped & ~i_we) ? {24'h0, acc.rdata} : 32'h0;
    end
  end
endmodule

//--- testbench/temp_channel_ctrl_properties.sv
// Concurrent checks on the temperature channel control top ports.
// Bound to every instance of the top; sees its ports only.
`timescale 1ns/10ps

module temp_channel_ctrl_properties (
  input wire logic i_clk, // clock
  input wire logic i_srst, // reset
  input wire logic i_wb_cyc, // cycle
  input wire logic i_wb_stb, // strobe
  input wire logic i_wb_we, // write
  input wire logic [7:0] i_wb_adr, // address
  input wire logic [3:0] i_wb_sel, // selects
  input wire logic [31:0] i_wb_dat, // write data
  input wire logic [31:0] o_wb_dat, // read data
  input wire logic o_wb_ack, // ack
  input wire logic i_analog_supply_up, // supply up
  input wire logic i_vlm_int_ref, // int ref
  input wire logic i_conv_valid, // result valid
  input wire logic i_conv_chan, // channel
  input wire logic [7:0] i_conv_temp, // result
  input wire logic i_conv_open, // open diode
  input wire logic [1:0] o_conv_run, // run
  input wire logic o_standby, // standby
  input wire logic o_ext_ref, // ext ref
  input wire logic [1:0] o_warning, // warning
  input wire logic [1:0] o_overtemp_shutdown, // shutdown
  input wire logic o_irq // irq
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  a_ack_after_req: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("no ack");
  a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack too long");
  a_ack_needs_req: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
    else $error("ack without request");
  a_read_upper_zero: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
    else $error("upper read data set");
  a_standby_no_run: assert property (o_standby [*2] |-> o_conv_run == 2'b00)
    else $error("run in standby");
  a_int_ref_wins: assert property (i_vlm_int_ref |=> !o_ext_ref)
    else $error("external ref kept");
  // Enable writes may follow the supply pulse, so run is left out here
  a_supply_clears: assert property (i_analog_supply_up ##1 !i_conv_valid |=>
      !o_irq && o_warning == 2'b00 && o_overtemp_shutdown == 2'b00)
    else $error("flags survive supply up");
  a_reset_state: assert property (disable iff (1'b0) i_srst |=> o_standby && o_ext_ref
      && !o_irq && o_conv_run == 2'b00 && !o_wb_ack)
    else $error("bad reset state");
endmodule

bind temp_channel_ctrl temp_channel_ctrl_properties u_props (.*);

//--- testbench/temp_channel_ctrl_tb.sv
// Self-checking bench for the temperature channel control block.
// Assumes wb_host_model drives the bus; read data is checked in order.
`timescale 1ns/10ps

module temp_channel_ctrl_tb;
  import temp_mon_pkg::*;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, hang;
  logic [7:0] i_wb_adr;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat;
  logic i_analog_supply_up = 1'b0;
  logic i_vlm_int_ref = 1'b0;
  logic i_conv_valid = 1'b0;
  logic i_conv_chan = 1'b0;
  logic [7:0] i_conv_temp = 8'h00;
  logic i_conv_open = 1'b0;
  logic [1:0] o_conv_run, o_warning, o_overtemp_shutdown;
  logic o_standby, o_ext_ref, o_irq;
  logic [31:0] seed = 32'h0673;
  logic [7:0] q[$];
  int n_mismatch = 0;
  int checked = 0;

  always #20 i_clk = ~i_clk;

  temp_channel_ctrl DUT (.*);
  wb_host_model u_host (.i_clk(i_clk), .i_ack(o_wb_ack), .o_cyc(i_wb_cyc), .o_stb(i_wb_stb),
    .o_we(i_wb_we), .o_adr(i_wb_adr), .o_sel(i_wb_sel), .o_dat(i_wb_dat), .o_hang(hang));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    u_host.acc(1'b1, {2'b00, i, 2'b00}, d);
  endtask

  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    q.push_back(e);
    u_host.acc(1'b0, {2'b00, i, 2'b00}, 8'h00);
  endtask

  task automatic settle();
    repeat (3) @(negedge i_clk);
  endtask

  task automatic conv(input logic [7:0] t, input logic o);
    @(posedge i_clk);
    i_conv_valid <= 1'b1;
    i_conv_temp <= t;
    i_conv_open <= o;
    @(posedge i_clk);
    i_conv_valid <= 1'b0;
    settle();
  endtask

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge i_clk) begin
    if (o_wb_ack === 1'b1 && i_wb_we === 1'b0) begin
      chk("read data", q.size() > 0 ? {24'h0, q.pop_front()} : 32'hx, o_wb_dat);
    end
  end

  always @(posedge hang) begin
    n_mismatch++;
    wrap_up();
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic [7:0] t, e;
    logic o, w, s;
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    rd(IDX_ROUTING, 8'h00);
    rd(IDX_GCFG, 8'h03);
    rd(IDX_BANK, 8'h00);
    rd(IDX_CFGST, 8'h00);
    rd(IDX_HI_LIM, 8'h7f);
    wr(IDX_ROUTING, 8'hff);
    rd(IDX_ROUTING, 8'h0f);
    u_host.acc(1'b1, 8'h90, 8'h00);
    rd(IDX_ROUTING, 8'h0f);
    rd(4'h1, 8'h00);
    conv(8'h40, 1'b0);
    rd(IDX_RESULT, 8'h00);
    wr(IDX_GCFG, 8'h02);
    @(posedge i_clk);
    i_vlm_int_ref <= 1'b1;
    settle();
    chk("ext ref", 32'h0, o_ext_ref);
    chk("standby", 32'h0, o_standby);
    @(posedge i_clk);
    i_vlm_int_ref <= 1'b0;
    settle();
    chk("ext ref", 32'h1, o_ext_ref);
    wr(IDX_BANK, 8'h01);
    wr(IDX_BANK, 8'h05);
    rd(IDX_BANK, 8'h01);
    rd(IDX_HI_LIM, 8'h7f);
    wr(IDX_BANK, 8'h10);
    rd(IDX_BANK, 8'h00);
    wr(IDX_HI_LIM, 8'h19);
    wr(IDX_OT_LIM, 8'h50);
    wr(IDX_CFGST, 8'h31);
    wr(IDX_ROUTING, 8'h03);
    settle();
    chk("run", 32'h1, o_conv_run);
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      t = r[7:0];
      o = r[8];
      e = {1'b1, o, 2'b11, $signed(t) > 8'sh50, $signed(t) > 8'sh19,
           $signed(t) < $signed(8'hc9), 1'b1};
      w = o | e[2] | e[1];
      s = o | e[3];
      conv(t, o);
      chk("warning", {31'h0, w}, o_warning);
      chk("shutdown", {31'h0, s}, o_overtemp_shutdown);
      chk("irq", {31'h0, w | s}, o_irq);
      rd(IDX_CFGST, e);
      rd(IDX_RESULT, t);
      wr(IDX_CFGST, 8'h31);
      rd(IDX_CFGST, e);
      wr(IDX_CFGST, 8'hff);
      rd(IDX_CFGST, 8'h31);
      settle();
      chk("irq", 32'h0, o_irq);
    end
    // Second channel: its own registers, outputs and routing bits
    wr(IDX_BANK, 8'h01);
    wr(IDX_CFGST, 8'h31);
    wr(IDX_ROUTING, 8'h08);
    i_conv_chan <= 1'b1;
    conv(8'h7f, 1'b1);
    chk("run", 32'h3, o_conv_run);
    chk("warning", 32'h2, o_warning);
    chk("shutdown", 32'h2, o_overtemp_shutdown);
    chk("irq", 32'h1, o_irq);
    rd(IDX_CFGST, 8'hf1);
    rd(IDX_RESULT, 8'h7f);
    wr(IDX_ROUTING, 8'h03);
    settle();
    chk("irq", 32'h0, o_irq);
    wr(IDX_ROUTING, 8'h04);
    settle();
    chk("irq", 32'h1, o_irq);
    wr(IDX_BANK, 8'h00);
    rd(IDX_RESULT, t);
    wr(IDX_GCFG, 8'h03);
    settle();
    chk("run", 32'h0, o_conv_run);
    rd(IDX_HI_LIM, 8'h19);
    @(posedge i_clk);
    i_analog_supply_up <= 1'b1;
    @(posedge i_clk);
    i_analog_supply_up <= 1'b0;
    rd(IDX_CFGST, 8'h00);
    settle();
    chk("irq", 32'h0, o_irq);
    chk("warning", 32'h0, o_warning);
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    rd(IDX_HI_LIM, 8'h7f);
    rd(IDX_ROUTING, 8'h00);
    @(posedge i_clk);
    chk("pending reads", 32'h0, q.size());
    wrap_up();
  end
endmodule

//--- testbench/wb_host_model.sv
// Host software model: classic Wishbone master issuing single cycles.
// Assumes a slave that acks each request; a missing ack raises o_hang.
`timescale 1ns/10ps

module wb_host_model (
  input wire logic i_clk, // clock
  input wire logic i_ack, // slave ack
  output logic o_cyc = 1'b0, // cycle
  output logic o_stb = 1'b0, // strobe
  output logic o_we = 1'b0, // write
  output logic [7:0] o_adr = 8'h00, // byte address
  output logic [3:0] o_sel = 4'h0, // byte selects
  output logic [31:0] o_dat = 32'h0, // write data
  output logic o_hang = 1'b0 // no ack in time
);
  // Strobe drops for a cycle after each ack, else the slave sees a second access
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we <= w;
    o_adr <= a;
    o_sel <= 4'hf;
    o_dat <= {24'h0, d};
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ack !== 1'b1 && n < 16);
    o_hang <= (i_ack !== 1'b1);
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
  endtask
endmodule
